//--- serial_port.sv
// Purpose: Serial programming port: UART framing, parity, baud, hold-off.
// Assumes: Settings image comes from non-volatile storage on cfg_nv_* at start-up.
// Notes:   Response bytes enter via the tx port; CR LF is appended on tx_last.
`timescale 1ns/10ps
`include "serial_port_params.svh"
module serial_port (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [8:0] cfg_nv_value,
  input  wire logic       cfg_nv_load,
  output logic [8:0]      cfg_nv_store,
  output logic            cfg_nv_write,
  input  wire logic [3:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [15:0]     reg_rdata,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_end_of_msg,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            parallel_bus_enable,
  output logic            txd,
  input  wire logic       rxd,
  output logic            rts,
  input  wire logic       cts,
  output logic            dtr,
  input  wire logic       dsr
);
  // Configuration
  logic [8:0] cfg_reg;
  logic [8:0] cfg_next;
  logic       nvw_next;
  logic       nvw_reg;
  serial_port_pkg::parity_t par_mode;
  serial_port_pkg::flow_t   flow_mode;
  logic [2:0] baud_sel;

  assign par_mode  = serial_port_pkg::parity_t'(cfg_reg[`CFG_PARITY_LSB +: 3]);
  assign baud_sel  = cfg_reg[`CFG_BAUD_LSB +: 3];
  assign flow_mode = serial_port_pkg::flow_t'(cfg_reg[`CFG_FLOW_LSB +: 2]);
  assign parallel_bus_enable = !cfg_reg[`CFG_SERIAL_BIT];
  assign cfg_nv_store = cfg_reg;
  assign cfg_nv_write = nvw_reg;

  always_comb begin
    cfg_next = cfg_reg;
    nvw_next = 1'b0;
    if (cfg_nv_load) begin
      cfg_next = cfg_nv_value;
    end else if (reg_write && reg_addr == `ADDR_CONFIG) begin
      cfg_next = reg_wdata[8:0];
      nvw_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_reg <= `CFG_RESET;
      nvw_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      nvw_reg <= nvw_next;
    end
  end

  // Baud tick: sixteen samples per bit
  logic [15:0] div_max;
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic        tick16;

  always_comb begin
    case (baud_sel)
      3'h0:    div_max = 16'(`CLK_HZ / (300 * 16) - 1);
      3'h1:    div_max = 16'(`CLK_HZ / (600 * 16) - 1);
      3'h2:    div_max = 16'(`CLK_HZ / (1200 * 16) - 1);
      3'h3:    div_max = 16'(`CLK_HZ / (2400 * 16) - 1);
      3'h4:    div_max = 16'(`CLK_HZ / (4800 * 16) - 1);
      default: div_max = 16'(`CLK_HZ / (9600 * 16) - 1);
    endcase
    tick16   = (div_reg >= div_max);
    div_next = tick16 ? 16'h0000 : 16'(div_reg + 16'h0001);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_next;
    end
  end

  // Pin synchronisers
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic       rxd_s;
  logic       cts_s;
  logic       dsr_s;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_meta_reg <= 3'h7;
      pin_sync_reg <= 3'h7;
    end else begin
      pin_meta_reg <= {dsr, cts, rxd};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign rxd_s = pin_sync_reg[0];
  assign cts_s = pin_sync_reg[1];
  assign dsr_s = pin_sync_reg[2];

  function automatic logic [7:0] frame_byte(input logic [7:0] d,
                                            input serial_port_pkg::parity_t p);
    logic [7:0] r;
    r = d;
    case (p)
      serial_port_pkg::PAR_EVEN:  r = {^d[6:0], d[6:0]};
      serial_port_pkg::PAR_ODD:   r = {~^d[6:0], d[6:0]};
      serial_port_pkg::PAR_MARK:  r = {1'b1, d[6:0]};
      serial_port_pkg::PAR_SPACE: r = {1'b0, d[6:0]};
      default:                    r = d;
    endcase
    return r;
  endfunction

  // Receiver
  serial_port_pkg::line_state_t rx_st_reg;
  serial_port_pkg::line_state_t rx_st_next;
  logic [3:0] rx_ph_reg;
  logic [3:0] rx_ph_next;
  logic [3:0] rx_bit_reg;
  logic [3:0] rx_bit_next;
  logic [7:0] rx_sh_reg;
  logic [7:0] rx_sh_next;
  logic       rx_done;
  logic       rx_perr;
  logic       rx_ferr;
  logic [7:0] rx_byte;

  assign rx_byte = (par_mode == serial_port_pkg::PAR_NONE) ? rx_sh_reg : {1'b0, rx_sh_reg[6:0]};

  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_ph_next  = rx_ph_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next  = rx_sh_reg;
    rx_done     = 1'b0;
    rx_ferr     = 1'b0;
    rx_perr     = 1'b0;
    if (tick16) begin
      rx_ph_next = 4'(rx_ph_reg + 4'h1);
      case (rx_st_reg)
        serial_port_pkg::LINE_IDLE: begin
          rx_ph_next = 4'h0;
          if (!rxd_s) begin
            rx_st_next  = serial_port_pkg::LINE_DATA;
            rx_bit_next = 4'h0;
          end
        end
        serial_port_pkg::LINE_DATA: begin
          if (rx_ph_reg == 4'h7 && rx_bit_reg == 4'h0 && rxd_s) begin
            rx_st_next = serial_port_pkg::LINE_IDLE;
          end else if (rx_ph_reg == 4'h7 && rx_bit_reg != 4'h0) begin
            rx_sh_next = {rxd_s, rx_sh_reg[7:1]};
          end
          if (rx_ph_reg == 4'hf) begin
            rx_bit_next = 4'(rx_bit_reg + 4'h1);
            if (rx_bit_reg == 4'(`FRAME_BITS - 2)) begin
              rx_st_next = serial_port_pkg::LINE_STOP;
            end
          end
        end
        serial_port_pkg::LINE_STOP: begin
          if (rx_ph_reg == 4'h7) begin
            rx_st_next = serial_port_pkg::LINE_IDLE;
            rx_done    = rxd_s;
            rx_ferr    = !rxd_s;
            rx_perr    = (frame_byte(rx_sh_reg, par_mode) != rx_sh_reg);
          end
        end
        default: rx_st_next = serial_port_pkg::LINE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_st_reg  <= serial_port_pkg::LINE_IDLE;
      rx_ph_reg  <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg  <= 8'h00;
    end else begin
      rx_st_reg  <= rx_st_next;
      rx_ph_reg  <= rx_ph_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg  <= rx_sh_next;
    end
  end

  // Receive buffer and flow control
  logic [7:0]       rxq_mem [`RX_DEPTH];
  logic [`RX_AW:0]  rxq_wp_reg;
  logic [`RX_AW:0]  rxq_wp_next;
  logic [`RX_AW:0]  rxq_rp_reg;
  logic [`RX_AW:0]  rxq_rp_next;
  logic [`RX_AW:0]  rxq_level;
  logic             rxq_push;
  logic             rxq_pop;
  logic             is_ctl;
  logic             host_hold_reg;
  logic             host_hold_next;
  logic             dev_hold_reg;
  logic             dev_hold_next;
  logic             xoff_pend_reg;
  logic             xoff_pend_next;
  logic             xon_pend_reg;
  logic             xon_pend_next;
  logic             ovr_reg;
  logic             ovr_next;
  logic             err_reg;
  logic             err_next;
  logic             ctl_sent;
  logic             xoff_sent;

  assign rxq_level = (`RX_AW+1)'(rxq_wp_reg - rxq_rp_reg);
  assign is_ctl = (flow_mode == serial_port_pkg::FLOW_XON) &&
                  (rx_byte == `BYTE_XOFF || rx_byte == `BYTE_XON);
  assign rxq_push = rx_done && !is_ctl && rxq_level != (`RX_AW+1)'(`RX_DEPTH);
  assign rxq_pop  = rx_valid && rx_ready;
  assign rx_valid = (rxq_level != '0);
  assign rx_data  = rxq_mem[rxq_rp_reg[`RX_AW-1:0]];
  assign rx_end_of_msg = (rx_data == `BYTE_NL);
  assign rts = (flow_mode == serial_port_pkg::FLOW_RTS) && dev_hold_reg;
  assign dtr = (flow_mode == serial_port_pkg::FLOW_DTR) && dev_hold_reg;

  always_comb begin
    rxq_wp_next    = rxq_push ? (`RX_AW+1)'(rxq_wp_reg + 1'b1) : rxq_wp_reg;
    rxq_rp_next    = rxq_pop ? (`RX_AW+1)'(rxq_rp_reg + 1'b1) : rxq_rp_reg;
    host_hold_next = host_hold_reg;
    case (flow_mode)
      serial_port_pkg::FLOW_XON: begin
        if (rx_done && rx_byte == `BYTE_XOFF) host_hold_next = 1'b1;
        if (rx_done && rx_byte == `BYTE_XON) host_hold_next = 1'b0;
      end
      serial_port_pkg::FLOW_RTS: host_hold_next = cts_s;
      serial_port_pkg::FLOW_DTR: host_hold_next = dsr_s;
      default: host_hold_next = 1'b0;
    endcase
    dev_hold_next = dev_hold_reg;
    if (rxq_level >= (`RX_AW+1)'(`RX_ALMOST_FULL)) dev_hold_next = 1'b1;
    else if (rxq_level <= (`RX_AW+1)'(`RX_RESUME)) dev_hold_next = 1'b0;
    if (flow_mode == serial_port_pkg::FLOW_NONE) dev_hold_next = 1'b0;
    xoff_pend_next = xoff_pend_reg;
    xon_pend_next  = xon_pend_reg;
    if (flow_mode == serial_port_pkg::FLOW_XON && dev_hold_next != dev_hold_reg) begin
      xoff_pend_next = dev_hold_next;
      xon_pend_next  = !dev_hold_next;
    end else if (ctl_sent) begin
      if (xoff_sent) xoff_pend_next = 1'b0;
      else xon_pend_next = 1'b0;
    end
    if (flow_mode != serial_port_pkg::FLOW_XON) begin
      xoff_pend_next = 1'b0;
      xon_pend_next  = 1'b0;
    end
    ovr_next = ovr_reg;
    err_next = err_reg;
    if (reg_read && reg_addr == `ADDR_STATUS) begin
      ovr_next = 1'b0;
      err_next = 1'b0;
    end
    if (rx_done && !is_ctl && !rxq_push) ovr_next = 1'b1;
    if (rx_ferr || (rx_done && rx_perr)) err_next = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rxq_push) rxq_mem[rxq_wp_reg[`RX_AW-1:0]] <= rx_byte;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxq_wp_reg    <= '0;
      rxq_rp_reg    <= '0;
      host_hold_reg <= 1'b0;
      dev_hold_reg  <= 1'b0;
      xoff_pend_reg <= 1'b0;
      xon_pend_reg  <= 1'b0;
      ovr_reg       <= 1'b0;
      err_reg       <= 1'b0;
    end else begin
      rxq_wp_reg    <= rxq_wp_next;
      rxq_rp_reg    <= rxq_rp_next;
      host_hold_reg <= host_hold_next;
      dev_hold_reg  <= dev_hold_next;
      xoff_pend_reg <= xoff_pend_next;
      xon_pend_reg  <= xon_pend_next;
      ovr_reg       <= ovr_next;
      err_reg       <= err_next;
    end
  end

  // Transmit path: buffer, terminator insertion, shifter
  logic [7:0] buf_data;
  logic       buf_valid;
  logic       buf_ready;
  logic [7:0] buf_in_data;
  logic       buf_in_valid;
  logic       buf_in_ready;
  logic       term_reg;
  logic       term_next;
  logic       last_reg;
  logic       last_next;

  // Response bytes then CR LF after tx_last
  always_comb begin
    term_next    = term_reg;
    last_next    = last_reg;
    buf_in_data  = tx_data;
    buf_in_valid = tx_valid && !term_reg;
    tx_ready     = buf_in_ready && !term_reg;
    if (term_reg) begin
      buf_in_valid = 1'b1;
      buf_in_data  = last_reg ? `BYTE_NL : `BYTE_CR;
      if (buf_in_ready) begin
        last_next = !last_reg;
        term_next = !last_reg;
      end
    end else if (tx_valid && buf_in_ready && tx_last) begin
      term_next = 1'b1;
      last_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      term_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      term_reg <= term_next;
      last_reg <= last_next;
    end
  end

  skid_buffer tx_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (buf_in_data),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );

  serial_port_pkg::line_state_t tx_st_reg;
  serial_port_pkg::line_state_t tx_st_next;
  logic [9:0] tx_sh_reg;
  logic [9:0] tx_sh_next;
  logic [3:0] tx_ph_reg;
  logic [3:0] tx_ph_next;
  logic [3:0] tx_bit_reg;
  logic [3:0] tx_bit_next;
  logic [2:0] tx_cnt_reg;
  logic [2:0] tx_cnt_next;
  logic       pace_ok;
  logic       ctl_sel;
  logic [7:0] tx_pick;

  // A hold-off from the host still lets a few queued characters out
  assign pace_ok = !host_hold_reg || tx_cnt_reg < 3'(`TX_HOLD_MAX);
  assign ctl_sel = xoff_pend_reg || xon_pend_reg;
  assign tx_pick = xoff_pend_reg ? `BYTE_XOFF : xon_pend_reg ? `BYTE_XON : buf_data;
  assign txd = tx_sh_reg[0];

  always_comb begin
    tx_st_next  = tx_st_reg;
    tx_sh_next  = tx_sh_reg;
    tx_ph_next  = tx_ph_reg;
    tx_bit_next = tx_bit_reg;
    tx_cnt_next = host_hold_reg ? tx_cnt_reg : 3'h0;
    buf_ready   = 1'b0;
    ctl_sent    = 1'b0;
    xoff_sent   = xoff_pend_reg;
    case (tx_st_reg)
      serial_port_pkg::LINE_IDLE: begin
        if (ctl_sel || (buf_valid && pace_ok)) begin
          tx_sh_next  = {1'b1, frame_byte(tx_pick, par_mode), 1'b0};
          tx_st_next  = serial_port_pkg::LINE_DATA;
          tx_ph_next  = 4'h0;
          tx_bit_next = 4'h0;
          ctl_sent    = ctl_sel;
          buf_ready   = !ctl_sel;
          if (!ctl_sel && host_hold_reg) tx_cnt_next = 3'(tx_cnt_reg + 3'h1);
        end
      end
      serial_port_pkg::LINE_DATA: begin
        if (tick16) begin
          tx_ph_next = 4'(tx_ph_reg + 4'h1);
          if (tx_ph_reg == 4'hf) begin
            tx_sh_next  = {1'b1, tx_sh_reg[9:1]};
            tx_bit_next = 4'(tx_bit_reg + 4'h1);
            if (tx_bit_reg == 4'(`FRAME_BITS - 1)) tx_st_next = serial_port_pkg::LINE_IDLE;
          end
        end
      end
      default: tx_st_next = serial_port_pkg::LINE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_reg  <= serial_port_pkg::LINE_IDLE;
      tx_sh_reg  <= 10'h3ff;
      tx_ph_reg  <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 3'h0;
    end else begin
      tx_st_reg  <= tx_st_next;
      tx_sh_reg  <= tx_sh_next;
      tx_ph_reg  <= tx_ph_next;
      tx_bit_reg <= tx_bit_next;
      tx_cnt_reg <= tx_cnt_next;
    end
  end

  // Register read port
  logic [15:0] rdata_next;
  logic [15:0] rdata_reg;

  always_comb begin
    rdata_next = 16'h0000;
    if (reg_read) begin
      case (reg_addr)
        `ADDR_CONFIG: rdata_next = {7'h00, cfg_reg};
        `ADDR_STATUS: rdata_next = {4'h0, ovr_reg, err_reg, 1'b0, rxq_level,
                                    dev_hold_reg, host_hold_reg};
        default:      rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;
endmodule

//--- serial_port_params.svh
// Purpose: Constants for the instrument serial port with hold-off.
// Assumes: 250 MHz system clock; host reaches settings over a plain register port.
// Notes:   One tag per rule line below.
// Function
// - While serial is selected, the parallel bus interface is disabled.
// - Each character is ten bit times: start, eight payload bits, stop.
// - Even/odd parity: seven data bits then computed parity bit.
// - Mark/space parity: seven data bits then parity fixed one or zero.
// - No parity: eight data bits, frame length unchanged.
// - Baud selectable from 300, 600, 1200, 2400, 4800, 9600.
// - Parity, baud, flow settings persist and load at start-up.
// - After host hold-off, transmitter sends at most five more characters.
// - After device hold-off, receiver still accepts fifteen more characters.
// - Software handshake: byte 19 holds off, byte 17 releases, both ways.
// - RTS/CTS: drive RTS near full, CTS input is host hold-off.
// - DTR/DSR: drive DTR near full, DSR input is host hold-off.
// - Flow none: ignore handshake lines and control bytes.
// - Device is DTE: transmits on TXD, receives on RXD.
// - Each response ends with carriage return then newline.
// - Received newline 0A ends an incoming program message.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

`define CLK_HZ           250000000
`define FRAME_BITS       10
`define BYTE_XOFF        8'h13
`define BYTE_XON         8'h11
`define BYTE_NL          8'h0a
`define BYTE_CR          8'h0d
`define TX_HOLD_MAX      5
`define RX_OVERRUN       15
`define RX_DEPTH         64
`define RX_AW            6
`define RX_ALMOST_FULL   (`RX_DEPTH - `RX_OVERRUN - 1)
`define RX_RESUME        16

`define ADDR_CONFIG      4'h0
`define ADDR_STATUS      4'h1
`define ADDR_TX          4'h2
`define ADDR_RX          4'h3

`define CFG_PARITY_LSB   0
`define CFG_BAUD_LSB     3
`define CFG_FLOW_LSB     6
`define CFG_SERIAL_BIT   8
`define CFG_RESET        9'h000

`endif

//--- serial_port_pkg.sv
// Purpose: Types for the instrument serial port.
// Assumes: Constants live in serial_port_params.svh.
// Notes:   Encodings match the configuration register fields.
package serial_port_pkg;
  typedef enum logic [2:0] {
    PAR_NONE  = 3'h0,
    PAR_EVEN  = 3'h1,
    PAR_ODD   = 3'h2,
    PAR_MARK  = 3'h3,
    PAR_SPACE = 3'h4
  } parity_t;

  typedef enum logic [1:0] {
    FLOW_NONE = 2'h0,
    FLOW_XON  = 2'h1,
    FLOW_RTS  = 2'h2,
    FLOW_DTR  = 2'h3
  } flow_t;

  typedef enum logic [1:0] {
    LINE_IDLE = 2'b00,
    LINE_DATA = 2'b01,
    LINE_STOP = 2'b11
  } line_state_t;
endpackage

//--- skid_buffer.sv
// Purpose: Two-entry buffer with valid/ready on both sides.
// Assumes: Same clock on both sides.
// Notes:   in_ready depends only on fill level, so no combinational loop.
`timescale 1ns/10ps
module skid_buffer (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  output logic [7:0]      out_data,
  output logic            out_valid,
  input  wire logic       out_ready
);
  logic [7:0] slot_reg [2];
  logic [7:0] slot_next [2];
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic       push;
  logic       pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = slot_reg[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    slot_next[0] = slot_reg[0];
    slot_next[1] = slot_reg[1];
    count_next   = count_reg;
    if (pop) begin
      slot_next[0] = slot_reg[1];
    end
    if (push) begin
      if (count_reg == 2'h0 || (count_reg == 2'h1 && pop)) begin
        slot_next[0] = in_data;
      end else begin
        slot_next[1] = in_data;
      end
    end
    count_next = 2'(count_reg + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slot_reg[0] <= 8'h00;
      slot_reg[1] <= 8'h00;
      count_reg   <= 2'h0;
    end else begin
      slot_reg[0] <= slot_next[0];
      slot_reg[1] <= slot_next[1];
      count_reg   <= count_next;
    end
  end
endmodule

//--- serial_port_chk_asserts.sv
// Purpose: Port-level checks for the serial port.
// Assumes: Single clock domain; synchronous active-high reset.
// Notes:   Bound to every serial_port instance.
`timescale 1ns/10ps
module serial_port_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [8:0]  cfg_nv_value,
  input wire logic        cfg_nv_load,
  input wire logic [8:0]  cfg_nv_store,
  input wire logic        cfg_nv_write,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic        tx_last,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_end_of_msg,
  input wire logic        rx_valid,
  input wire logic        parallel_bus_enable,
  input wire logic        txd,
  input wire logic        rts,
  input wire logic        dtr
);
  logic [1:0] flow_d;

  always_ff @(posedge clk_sys) begin
    flow_d <= cfg_nv_store[7:6];
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_idle: assert property ($past(rst) |-> txd && !rts && !dtr)
    else $error("lines not idle after reset");
  a_rdata_zero: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  a_nv_restore: assert property ($past(cfg_nv_load) && !$past(rst) |->
    cfg_nv_store == $past(cfg_nv_value))
    else $error("stored settings not restored");
  a_cfg_write: assert property (reg_write && reg_addr == 4'h0 |=>
    cfg_nv_write && {7'h00, cfg_nv_store} == ($past(reg_wdata) & 16'h01ff))
    else $error("config write not stored");
  a_bus_off: assert property (parallel_bus_enable == !cfg_nv_store[8])
    else $error("parallel bus state wrong");
  a_crlf_gap: assert property (tx_valid && tx_ready && tx_last |=> !tx_ready [*2])
    else $error("tx accepted during line end");
  a_eom_flag: assert property (rx_valid |-> rx_end_of_msg == (rx_data == 8'h0a))
    else $error("end of message flag wrong");
  a_par_bit: assert property (rx_valid && cfg_nv_store[2:0] != 3'h0 |-> !rx_data[7])
    else $error("parity bit leaked to data");
  a_rts_mode: assert property (cfg_nv_store[7:6] != 2'h2 && flow_d != 2'h2 |-> !rts)
    else $error("rts outside its mode");
  a_dtr_mode: assert property (cfg_nv_store[7:6] != 2'h3 && flow_d != 2'h3 |-> !dtr)
    else $error("dtr outside its mode");

  c_tx_last: cover property (tx_valid && tx_ready && tx_last);
  c_rx_eom: cover property (rx_valid && rx_end_of_msg);
  c_cfg_wr: cover property (cfg_nv_write);
endmodule

bind serial_port serial_port_chk chk_u (.*);

//--- host_uart_model.sv
// Purpose: Host serial port model, even parity, seven data bits.
// Assumes: Bit time in system clocks matches the device divider.
// Notes:   got carries stop bit in [8]; line idles high (mark).
`timescale 1ns/10ps
module host_uart_model #(
  parameter int BIT_CYC = 26032
) (
  input wire logic clk_sys,
  input wire logic line_in,
  output logic     line_out,
  output logic [8:0] got,
  output logic     got_stb
);
  logic [8:0] sh;

  initial begin
    line_out = 1'b1;
    got_stb = 1'b0;
    got = 9'h000;
  end

  // One start, seven data, even parity, one stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, ^b[6:0], b[6:0], 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT_CYC) @(posedge clk_sys);
    end
  endtask

  // Mid-bit sampling from the start edge
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge clk_sys);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys);
      sh[i] = line_in;
    end
    got <= sh;
    got_stb <= 1'b1;
    @(posedge clk_sys);
    got_stb <= 1'b0;
  end
endmodule

//--- instrument_serial_port_with_holdoff_tb_top.sv
// Purpose: Self-checking bench for the serial port.
// Assumes: 9600 baud keeps every frame near 26k clocks per bit.
// Notes:   Expected results go into queues, monitors pop and compare.
`timescale 1ns/10ps
module instrument_serial_port_with_holdoff_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [8:0]  cfg_nv_value = 9'h000;
  logic        cfg_nv_load = 1'b0;
  logic [8:0]  cfg_nv_store;
  logic        cfg_nv_write;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0]  tx_data = 8'h00;
  logic        tx_last = 1'b0;
  logic        tx_valid = 1'b0;
  logic        tx_ready;
  logic [7:0]  rx_data;
  logic        rx_end_of_msg;
  logic        rx_valid;
  logic        rx_ready = 1'b0;
  logic        parallel_bus_enable;
  logic        txd;
  logic        rxd;
  logic        rts;
  logic        dtr;
  logic        cts = 1'b0;
  logic        dsr = 1'b0;
  logic [8:0]  got;
  logic        got_stb;
  logic        rd_d = 1'b0;
  logic [31:0] seed = 32'ha58eb47b;
  logic [7:0]  d;
  logic [7:0]  r;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [15:0] rdq[$];
  logic [8:0]  hq[$];
  logic [8:0]  xq[$];

  always #2 clk_sys = ~clk_sys;

  serial_port dut_u (
    .clk_sys(clk_sys), .rst(rst), .cfg_nv_value(cfg_nv_value), .cfg_nv_load(cfg_nv_load),
    .cfg_nv_store(cfg_nv_store), .cfg_nv_write(cfg_nv_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_end_of_msg(rx_end_of_msg),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .parallel_bus_enable(parallel_bus_enable),
    .txd(txd), .rxd(rxd), .rts(rts), .cts(cts), .dtr(dtr), .dsr(dsr));

  host_uart_model host_u (
    .clk_sys(clk_sys), .line_in(txd), .line_out(rxd), .got(got), .got_stb(got_stb));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    rdq.push_back(e);
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Host frame with stop bit as seen on the wire
  function automatic logic [8:0] frame(input logic [7:0] b);
    return {1'b1, ^b[6:0], b[6:0]};
  endfunction

  always @(posedge clk_sys) begin
    if (rd_d) chk("reg_rdata", rdq.pop_front(), reg_rdata);
    rd_d <= reg_read;
    if (got_stb) chk("host_rx", {7'h00, hq.pop_front()}, {7'h00, got});
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      chk("rx_out", {7'h00, xq.pop_front()}, {7'h00, rx_end_of_msg, rx_data});
    cyc++;
    if (cyc == 1200000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("txd_idle", 16'h0001, {15'h0, txd});
    chk("hold_lines", 16'h0000, {14'h0, rts, dtr});
    chk("pbus_on", 16'h0001, {15'h0, parallel_bus_enable});
    reg_rd(4'h0, 16'h0000);
    cfg_nv_value <= 9'h1a9;
    cfg_nv_load <= 1'b1;
    @(posedge clk_sys);
    cfg_nv_load <= 1'b0;
    @(posedge clk_sys);
    chk("pbus_off", 16'h0000, {15'h0, parallel_bus_enable});
    reg_rd(4'h0, 16'h01a9);
    reg_wr(4'h0, 16'h00d1);
    chk("nv_store", 16'h00d1, {7'h0, cfg_nv_store});
    chk("pbus_back", 16'h0001, {15'h0, parallel_bus_enable});
    reg_wr(4'h9, 16'hffff);
    reg_rd(4'h9, 16'h0000);
    reg_rd(4'h0, 16'h00d1);
    reg_rd(4'h1, 16'h0000);
    reg_wr(4'h0, 16'h01a9);
    seed = lfsr(seed);
    d = {1'b0, seed[6:0]};
    seed = lfsr(seed);
    r = {1'b0, seed[14:8]};
    hq.push_back(frame(d));
    hq.push_back(frame(8'h0d));
    hq.push_back(frame(8'h0a));
    xq.push_back({1'b1, 8'h0a});
    xq.push_back({(r == 8'h0a), r});
    fork
      begin
        tx_data <= d;
        tx_last <= 1'b1;
        tx_valid <= 1'b1;
        do @(posedge clk_sys); while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end
      begin
        host_u.send(8'h0a);
        host_u.send(r);
      end
    join
    repeat (4) @(posedge clk_sys);
    reg_rd(4'h1, 16'h0008);
    rx_ready <= 1'b1;
    wait (hq.size() == 0 && xq.size() == 0);
    repeat (4) @(posedge clk_sys);
    // Host hold-off lines per flow mode, seen through the status register
    cts <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reg_rd(4'h1, 16'h0001);
    reg_wr(4'h0, 16'h01e9);
    reg_rd(4'h1, 16'h0000);
    dsr <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reg_rd(4'h1, 16'h0001);
    reg_wr(4'h0, 16'h0129);
    reg_rd(4'h1, 16'h0000);
    end_sim();
  end
endmodule
